// ### shared/fsr_consts.svh
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

// Status byte widths and read sequence length
`define FSR_BYTE_W        8
`define FSR_WORD_BITS     16
`define FSR_BITCNT_W      4

// Lower status byte field positions
`define FSR_LB_LOCK       7
`define FSR_LB_RSV        6
`define FSR_LB_FAIL       5
`define FSR_LB_WPP        4
`define FSR_LB_SUM_HI     3
`define FSR_LB_SUM_LO     2
`define FSR_LB_WEL        1
`define FSR_BUSY_BIT      0

// Upper status byte field positions
`define FSR_UB_RSV_HI     7
`define FSR_UB_RSV_LO     5
`define FSR_UB_RST        4
`define FSR_UB_LDA        3
`define FSR_UB_PS         2
`define FSR_UB_ES         1

// Write data bit positions of the two status write commands
`define FSR_W1_LOCK       7
`define FSR_W2_RST        4
`define FSR_W2_LDA        3

// Protection summary codes
`define FSR_SUM_NONE      2'h0
`define FSR_SUM_SOME      2'h1
`define FSR_SUM_ALL       2'h3
`define FSR_SUM_RSV       2'h2

// Reset values, plus link counter and shift constants
`define FSR_RST_BIT       1'h0
`define FSR_RST_SUM       2'h3
`define FSR_RST_RSV3      3'h0
`define FSR_RST_BYTE      8'h00
`define FSR_RST_SYNC      3'h7
`define FSR_RST_REQ       3'h0
`define FSR_RST_CNT       4'h0
`define FSR_CNT_ONE       4'h1
`define FSR_BYTE_START    3'h0
`define FSR_SHIFT_FILL    1'h0

`endif

// ### shared/fsr_pkg.sv
`include "fsr_consts.svh"

package fsr_pkg;

  typedef logic [`FSR_BYTE_W-1:0] fsr_byte_t;

  typedef logic [`FSR_BITCNT_W-1:0] fsr_bitcnt_t;

  typedef logic [1:0] fsr_summary_t;

endpackage

// ### core/fsr_status_regs.sv
module fsr_status_regs
  import fsr_pkg::*;
(
  // System clock and power-up reset
  input  wire logic       CLK,
  input  wire logic       SRST,
  // Protect pin, active low, from outside
  input  wire logic       WP_N,
  // Command events from the decoder, one-cycle pulses on CLK
  input  wire logic       WREN_DONE,
  input  wire logic       WRDI_DONE,
  input  wire logic       PROT_OP_END,
  input  wire logic       HOLD_ABORT,
  input  wire logic       WSR1_DONE,
  input  wire fsr_byte_t  WSR1_DATA,
  input  wire logic       WSR2_DONE,
  input  wire fsr_byte_t  WSR2_DATA,
  input  wire logic       FREEZE_DONE,
  input  wire logic       SW_RESET_REQ,
  input  wire logic       OP_END,
  input  wire logic       OP_ABORTED,
  input  wire logic       OP_FAIL,
  // Array state levels on CLK
  input  wire logic       BUSY,
  input  wire logic       PROG_SUSP,
  input  wire logic       ERASE_SUSP,
  input  wire logic       ANY_SECT_PROT,
  input  wire logic       ALL_SECT_PROT,
  // Permissions and status to the decoder
  output logic            SECT_PROT_OK,
  output logic            MODIFY_OK,
  output logic            LOCKDOWN_OK,
  output logic            SOFT_RESET_GO,
  output fsr_byte_t       STATUS_LOWER,
  output fsr_byte_t       STATUS_UPPER,
  // Serial link, on the link clock
  input  wire logic       SCK,
  input  wire logic       CS_N,
  input  wire logic       RD_STAT_GO,
  output logic            SO,
  output logic            SO_OE
);

  // Status state on CLK
  logic         lock;
  logic         op_fail;
  logic         write_latch;
  logic         rst_allow;
  logic         ld_allow;
  logic         frozen;
  logic [2:0]   wp_sync;
  logic         wp_asserted;
  fsr_byte_t    mbox_lower;
  fsr_byte_t    mbox_upper;
  logic [2:0]   req_sync;
  logic         req_seen;

  // Link state on SCK
  fsr_bitcnt_t  bit_cnt;
  fsr_byte_t    shift;
  logic         req_tgl;

  // Decoding
  wire logic          wsr1_ok     = WSR1_DONE & write_latch;
  wire logic          wsr2_ok     = WSR2_DONE & write_latch;
  wire logic          new_lock    = WSR1_DATA[`FSR_W1_LOCK];
  wire logic          lock_wr_ok  = wsr1_ok & (~wp_asserted | new_lock);
  wire logic          reset_grant = SW_RESET_REQ & rst_allow;
  wire logic          latch_clr   = WRDI_DONE | PROT_OP_END | HOLD_ABORT | WSR1_DONE
                                    | WSR2_DONE | reset_grant;
  wire logic          freeze_ok   = FREEZE_DONE & write_latch & ld_allow;
  wire logic          fail_upd    = OP_END & ~OP_ABORTED;
  wire logic          wp_settled  = wp_sync[1] == wp_sync[2];
  wire logic          req_settled = req_sync[1] == req_sync[2];
  wire logic          req_new     = req_settled & (req_sync[2] != req_seen);
  wire fsr_summary_t  summary     = ALL_SECT_PROT ? `FSR_SUM_ALL :
                                    ANY_SECT_PROT ? `FSR_SUM_SOME : `FSR_SUM_NONE;
  fsr_byte_t          lower_now;
  fsr_byte_t          upper_now;

  assign lower_now[`FSR_LB_LOCK]                 = lock;
  assign lower_now[`FSR_LB_RSV]                  = `FSR_RST_BIT;
  assign lower_now[`FSR_LB_FAIL]                 = op_fail;
  assign lower_now[`FSR_LB_WPP]                  = ~wp_asserted;
  assign lower_now[`FSR_LB_SUM_HI:`FSR_LB_SUM_LO] = summary;
  assign lower_now[`FSR_LB_WEL]                  = write_latch;
  assign lower_now[`FSR_BUSY_BIT]                = BUSY;
  assign upper_now[`FSR_UB_RSV_HI:`FSR_UB_RSV_LO] = `FSR_RST_RSV3;
  assign upper_now[`FSR_UB_RST]                  = rst_allow;
  assign upper_now[`FSR_UB_LDA]                  = ld_allow;
  assign upper_now[`FSR_UB_PS]                   = PROG_SUSP;
  assign upper_now[`FSR_UB_ES]                   = ERASE_SUSP;
  assign upper_now[`FSR_BUSY_BIT]                = BUSY;

  // Protect pin: three stages, a change counts once the last two agree
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      wp_sync     <= `FSR_RST_SYNC;
      wp_asserted <= `FSR_RST_BIT;
    end
    else
    begin
      wp_sync <= {wp_sync[1:0], WP_N};
      if (wp_settled)
        wp_asserted <= ~wp_sync[2];
    end
  end

  // Lock bit: only writer is the lower-byte write; reset request ignored
  always_ff @(posedge CLK)
  begin
    if (SRST)
      lock <= `FSR_RST_BIT;
    else if (lock_wr_ok)
      lock <= new_lock;
  end

  // Failure flag follows completed operations only
  always_ff @(posedge CLK)
  begin
    if (SRST)
      op_fail <= `FSR_RST_BIT;
    else if (fail_upd)
      op_fail <= OP_FAIL;
  end

  // Write latch; a set in the same cycle as a clear wins.
  // Aborts before a full opcode never raise any clear event.
  always_ff @(posedge CLK)
  begin
    if (SRST)
      write_latch <= `FSR_RST_BIT;
    else if (WREN_DONE)
      write_latch <= 1'b1;
    else if (latch_clr)
      write_latch <= `FSR_RST_BIT;
  end

  // Upper-byte permissions: only the upper-byte write, the freeze command and power-up change them
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      rst_allow <= `FSR_RST_BIT;
      ld_allow  <= `FSR_RST_BIT;
      frozen    <= `FSR_RST_BIT;
    end
    else
    begin
      if (wsr2_ok)
        rst_allow <= WSR2_DATA[`FSR_W2_RST];
      if (freeze_ok)
        frozen <= 1'b1;
      if (freeze_ok | frozen)
        ld_allow <= `FSR_RST_BIT;
      else if (wsr2_ok)
        ld_allow <= WSR2_DATA[`FSR_W2_LDA];
    end
  end

  // Registered permissions and status to the decoder
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      SECT_PROT_OK  <= `FSR_RST_BIT;
      MODIFY_OK     <= `FSR_RST_BIT;
      LOCKDOWN_OK   <= `FSR_RST_BIT;
      SOFT_RESET_GO <= `FSR_RST_BIT;
      STATUS_LOWER  <= `FSR_RST_BYTE;
      STATUS_UPPER  <= `FSR_RST_BYTE;
    end
    else
    begin
      SECT_PROT_OK  <= write_latch & ~lock;
      MODIFY_OK     <= write_latch;
      LOCKDOWN_OK   <= write_latch & ld_allow;
      SOFT_RESET_GO <= reset_grant;
      STATUS_LOWER  <= lower_now;
      STATUS_UPPER  <= upper_now;
    end
  end

  // Mailbox: refreshed only on a new byte request from the link, so it is
  // stable for a whole byte time whenever the link loads from it
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      req_sync   <= `FSR_RST_REQ;
      req_seen   <= `FSR_RST_BIT;
      mbox_lower <= `FSR_RST_BYTE;
      mbox_upper <= `FSR_RST_BYTE;
    end
    else
    begin
      req_sync <= {req_sync[1:0], req_tgl};
      if (req_new)
      begin
        req_seen   <= req_sync[2];
        mbox_lower <= lower_now;
        mbox_upper <= upper_now;
      end
    end
  end

  // Link side: chip select high ends the frame without needing clock edges
  wire logic      byte_start = bit_cnt[2:0] == `FSR_BYTE_START;
  wire fsr_byte_t next_byte  = bit_cnt[3] ? mbox_upper : mbox_lower;

  always_ff @(posedge SCK or posedge CS_N)
  begin
    if (CS_N)
    begin
      bit_cnt <= `FSR_RST_CNT;
      shift   <= `FSR_RST_BYTE;
      req_tgl <= `FSR_RST_BIT;
      SO      <= `FSR_RST_BIT;
      SO_OE   <= `FSR_RST_BIT;
    end
    else
    begin
      SO_OE <= RD_STAT_GO;
      if (RD_STAT_GO)
      begin
        bit_cnt <= bit_cnt + `FSR_CNT_ONE;
        if (byte_start)
        begin
          SO      <= next_byte[`FSR_BYTE_W-1];
          shift   <= {next_byte[`FSR_BYTE_W-2:0], `FSR_SHIFT_FILL};
          req_tgl <= ~req_tgl;
        end
        else
        begin
          SO    <= shift[`FSR_BYTE_W-1];
          shift <= {shift[`FSR_BYTE_W-2:0], `FSR_SHIFT_FILL};
        end
      end
    end
  end

  // Checks
  lock_wp_hold_a: assert property (@(posedge CLK) disable iff (SRST)
    (wp_asserted && lock && !SRST) |=> lock)
    else $error("lock bit cleared while protect pin asserted");

  lock_swreset_a: assert property (@(posedge CLK) disable iff (SRST)
    (SW_RESET_REQ && !WSR1_DONE) |=> $stable(lock))
    else $error("software reset altered lock bit");

  fail_set_a: assert property (@(posedge CLK) disable iff (SRST)
    (OP_END && !OP_ABORTED) |=> (op_fail == $past(OP_FAIL)) ##1 (STATUS_LOWER[`FSR_LB_FAIL]
    == $past(op_fail)))
    else $error("failure flag not refreshed after operation");

  fail_abort_a: assert property (@(posedge CLK) disable iff (SRST)
    (OP_END && OP_ABORTED) |=> $stable(op_fail))
    else $error("aborted operation changed failure flag");

  latch_clear_a: assert property (@(posedge CLK) disable iff (SRST)
    ((WRDI_DONE || PROT_OP_END || HOLD_ABORT) && !WREN_DONE) |=> !write_latch ##1
    !MODIFY_OK)
    else $error("write latch not cleared");

  refuse_write_a: assert property (@(posedge CLK) disable iff (SRST)
    (WSR2_DONE && !write_latch) |=> $stable(rst_allow) && $stable(ld_allow))
    else $error("upper byte written without write latch");

  frozen_zero_a: assert property (@(posedge CLK) disable iff (SRST)
    frozen |=> !ld_allow ##1 !STATUS_UPPER[`FSR_UB_LDA])
    else $error("lockdown-allow set after freeze");

  reset_gate_a: assert property (@(posedge CLK) disable iff (SRST)
    (SW_RESET_REQ && !rst_allow) |=> !SOFT_RESET_GO)
    else $error("software reset honoured while disabled");

  reserved_zero_a: assert property (@(posedge CLK) disable iff (SRST)
    STATUS_UPPER[`FSR_UB_RSV_HI:`FSR_UB_RSV_LO] == `FSR_RST_RSV3)
    else $error("reserved upper bits not zero");

  pin_level_a: assert property (@(posedge CLK) disable iff (SRST)
    wp_asserted |=> !STATUS_LOWER[`FSR_LB_WPP])
    else $error("pin level bit wrong while pin asserted");

  sect_lock_a: assert property (@(posedge CLK) disable iff (SRST)
    lock |=> !SECT_PROT_OK)
    else $error("sector protect allowed while locked");

  lock_set_a: assert property (@(posedge CLK) disable iff (SRST)
    (wsr1_ok && new_lock) |=> lock)
    else $error("lock bit not set by a permitted write");

  lower_write_a: assert property (@(posedge CLK) disable iff (SRST)
    (WSR1_DONE && !fail_upd) |=> $stable(op_fail))
    else $error("lower byte write altered failure flag");

  modify_gate_a: assert property (@(posedge CLK) disable iff (SRST)
    !write_latch |=> !MODIFY_OK)
    else $error("modify allowed without write latch");

  freeze_gate_a: assert property (@(posedge CLK) disable iff (SRST)
    (FREEZE_DONE && !ld_allow && !frozen) |=> !frozen)
    else $error("freeze taken while lockdown disabled");

  rst_keep_a: assert property (@(posedge CLK) disable iff (SRST)
    !wsr2_ok |=> $stable(rst_allow))
    else $error("reset-allow changed without upper byte write");

  ld_keep_a: assert property (@(posedge CLK) disable iff (SRST)
    (!wsr2_ok && !freeze_ok) |=> $stable(ld_allow))
    else $error("lockdown-allow changed without upper byte write");

  suspend_map_a: assert property (@(posedge CLK) disable iff (SRST)
    1'b1 |=> (STATUS_UPPER[`FSR_UB_PS] == $past(PROG_SUSP))
    && (STATUS_UPPER[`FSR_UB_ES] == $past(ERASE_SUSP)))
    else $error("suspend bits do not follow suspend levels");

  busy_map_a: assert property (@(posedge CLK) disable iff (SRST)
    1'b1 |=> (STATUS_LOWER[`FSR_BUSY_BIT] == $past(BUSY))
    && (STATUS_UPPER[`FSR_BUSY_BIT] == $past(BUSY)))
    else $error("busy bit does not follow busy level");

  lower_map_a: assert property (@(posedge CLK) disable iff (SRST)
    1'b1 |=> (STATUS_LOWER[`FSR_LB_LOCK] == $past(lock))
    && (STATUS_LOWER[`FSR_LB_WEL] == $past(write_latch)) && !STATUS_LOWER[`FSR_LB_RSV])
    else $error("lower byte layout wrong");

  summary_code_a: assert property (@(posedge CLK) disable iff (SRST)
    STATUS_LOWER[`FSR_LB_SUM_HI:`FSR_LB_SUM_LO] != `FSR_SUM_RSV)
    else $error("reserved summary code shown");

  reset_latch_a: assert property (@(posedge CLK) disable iff (SRST)
    (SW_RESET_REQ && rst_allow && !WREN_DONE) |=> SOFT_RESET_GO && !write_latch)
    else $error("honoured reset left write latch set");

  status_read_c: cover property (@(posedge SCK) disable iff (CS_N)
    RD_STAT_GO [*8] ##1 RD_STAT_GO);

  lock_set_c: cover property (@(posedge CLK) disable iff (SRST)
    wp_asserted && lock_wr_ok && new_lock);

  freeze_c: cover property (@(posedge CLK) disable iff (SRST) freeze_ok);

  fail_c: cover property (@(posedge CLK) disable iff (SRST) fail_upd && OP_FAIL);

  upper_write_c: cover property (@(posedge CLK) disable iff (SRST)
    wsr2_ok && WSR2_DATA[`FSR_W2_RST]);

endmodule

// ### bench/fsr_host_model.sv
module fsr_host_model (
  // Serial link driven by the host
  output logic      SCK,
  output logic      CS_N,
  output logic      RD_STAT_GO,
  // Data returned by the device
  input  wire logic SO,
  input  wire logic SO_OE
);
  timeunit 1ns;
  timeprecision 100ps;

  int oe_bad;

  // Clock stands low outside frames
  initial
  begin
    SCK = 1'b0;
    CS_N = 1'b1;
    RD_STAT_GO = 1'b0;
    oe_bad = 0;
  end

  task automatic shift_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      #7.5 SCK = 1'b1;
      #7.5 SCK = 1'b0;
      if (SO_OE !== 1'b1) oe_bad++;
      b = {b[6:0], SO};
    end
  endtask

  task automatic open_frame;
    CS_N = 1'b0;
    #7.5 RD_STAT_GO = 1'b1;
  endtask

  task automatic close_frame;
    #7.5 RD_STAT_GO = 1'b0;
    CS_N = 1'b1;
    #15 if (SO_OE !== 1'b0) oe_bad++;
  endtask

  // Early bytes may be stale, so the third and fourth are kept
  task automatic read_word(output logic [15:0] w);
    logic [7:0] b;
    open_frame();
    repeat (4)
    begin
      shift_byte(b);
      w = {w[7:0], b};
    end
    close_frame();
  endtask

  // Keeps clocking fresh status until busy falls
  task automatic poll_ready(output bit fell);
    logic [7:0] b;
    bit         seen;
    seen = 1'b0;
    fell = 1'b0;
    open_frame();
    repeat (64)
    begin
      if (!fell)
      begin
        shift_byte(b);
        if (b[0] === 1'b1) seen = 1'b1;
        else if (seen && b[0] === 1'b0) fell = 1'b1;
      end
    end
    close_frame();
  endtask
endmodule

// ### bench/fsr_testbench.sv
module testbench
  import fsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       CLK, SRST, WP_N, BUSY, PROG_SUSP, ERASE_SUSP;
  logic       any_prot, all_prot, OP_ABORTED, OP_FAIL;
  logic [8:0] ev;
  fsr_byte_t  wdata, lower, upper;
  logic       sect_ok, mod_ok, ld_ok, rst_go, sck, cs_n, rd_go, so, so_oe;
  logic [15:0] w;
  bit         fell;
  int         errors, samples_checked, rst_seen;

  fsr_status_regs uut (
    .CLK(CLK), .SRST(SRST), .WP_N(WP_N),
    .WREN_DONE(ev[0]), .WRDI_DONE(ev[1]), .PROT_OP_END(ev[2]), .HOLD_ABORT(ev[3]),
    .WSR1_DONE(ev[4]), .WSR1_DATA(wdata), .WSR2_DONE(ev[5]), .WSR2_DATA(wdata),
    .FREEZE_DONE(ev[6]), .SW_RESET_REQ(ev[7]), .OP_END(ev[8]),
    .OP_ABORTED(OP_ABORTED), .OP_FAIL(OP_FAIL), .BUSY(BUSY), .PROG_SUSP(PROG_SUSP),
    .ERASE_SUSP(ERASE_SUSP), .ANY_SECT_PROT(any_prot), .ALL_SECT_PROT(all_prot),
    .SECT_PROT_OK(sect_ok), .MODIFY_OK(mod_ok), .LOCKDOWN_OK(ld_ok),
    .SOFT_RESET_GO(rst_go), .STATUS_LOWER(lower), .STATUS_UPPER(upper),
    .SCK(sck), .CS_N(cs_n), .RD_STAT_GO(rd_go), .SO(so), .SO_OE(so_oe));

  fsr_host_model host (.SCK(sck), .CS_N(cs_n), .RD_STAT_GO(rd_go), .SO(so), .SO_OE(so_oe));

  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  always @(posedge CLK) if (rst_go === 1'b1) rst_seen++;

  task automatic report_and_stop;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_byte(fsr_byte_t act, fsr_byte_t exp);
    samples_checked++;
    if (act !== exp)
    begin
      errors++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, act, exp);
    end
  endtask

  task automatic chk_bit(logic act, logic exp);
    samples_checked++;
    if (act !== exp)
    begin
      errors++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, act, exp);
    end
  endtask

  task automatic settle(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // Event pulse of one cycle, then wait until status shows it
  task automatic pulse(int i);
    @(posedge CLK);
    #1 ev[i] = 1'b1;
    @(posedge CLK);
    #1 ev = 9'h000;
    settle(3);
  endtask

  task automatic t_reset;
    chk_byte(lower, 8'h1C);
    chk_byte(upper, 8'h00);
  endtask

  task automatic t_summary_pin;
    any_prot = 1'b0;
    all_prot = 1'b0;
    settle(3);
    chk_byte(lower, 8'h10);
    any_prot = 1'b1;
    settle(3);
    chk_byte(lower, 8'h14);
    all_prot = 1'b1;
    WP_N = 1'b0;
    settle(6);
    chk_byte(lower, 8'h0C);
    WP_N = 1'b1;
    settle(6);
    chk_byte(lower, 8'h1C);
  endtask

  task automatic t_latch;
    pulse(0);
    chk_byte(lower, 8'h1E);
    settle(4);
    chk_bit(mod_ok, 1'b1);
    for (int i = 1; i < 4; i++)
    begin
      if (i > 1) pulse(0);
      pulse(i);
      chk_bit(mod_ok, 1'b0);
    end
  endtask

  task automatic t_lock;
    wdata = 8'hFF;
    pulse(4);
    chk_byte(lower, 8'h1C);
    pulse(0);
    chk_bit(sect_ok, 1'b1);
    pulse(4);
    chk_byte(lower, 8'h9C);
    pulse(0);
    chk_bit(sect_ok, 1'b0);
    WP_N = 1'b0;
    wdata = 8'h00;
    settle(6);
    pulse(4);
    chk_byte(lower, 8'h8C);
    WP_N = 1'b1;
    settle(6);
    pulse(0);
    pulse(4);
    chk_byte(lower, 8'h1C);
  endtask

  task automatic t_upper;
    wdata = 8'hFF;
    pulse(0);
    pulse(5);
    chk_byte(upper, 8'h18);
    pulse(0);
    chk_bit(ld_ok, 1'b1);
    pulse(7);
    chk_bit(rst_seen == 1, 1'b1);
    chk_byte(upper, 8'h18);
    chk_byte(lower, 8'h1C);
    pulse(0);
    pulse(6);
    chk_byte(upper, 8'h10);
    pulse(0);
    pulse(5);
    chk_byte(upper, 8'h10);
    pulse(0);
    chk_bit(ld_ok, 1'b0);
    wdata = 8'h00;
    pulse(5);
    chk_byte(upper, 8'h00);
    pulse(7);
    chk_bit(rst_seen == 1, 1'b1);
  endtask

  task automatic t_fail;
    OP_FAIL = 1'b1;
    pulse(8);
    chk_byte(lower, 8'h3C);
    OP_FAIL = 1'b0;
    pulse(8);
    chk_byte(lower, 8'h1C);
    OP_FAIL = 1'b1;
    OP_ABORTED = 1'b1;
    pulse(8);
    chk_byte(lower, 8'h1C);
  endtask

  task automatic t_serial;
    PROG_SUSP = 1'b1;
    ERASE_SUSP = 1'b1;
    BUSY = 1'b1;
    settle(3);
    chk_byte(upper, 8'h07);
    host.read_word(w);
    chk_byte(w[15:8], 8'h1D);
    chk_byte(w[7:0], 8'h07);
    fork
      host.poll_ready(fell);
      begin
        settle(60);
        BUSY = 1'b0;
      end
    join
    chk_bit(fell, 1'b1);
    chk_bit(host.oe_bad == 0, 1'b1);
  endtask

  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial
  begin
    {SRST, WP_N, any_prot, all_prot} = 4'hF;
    {BUSY, PROG_SUSP, ERASE_SUSP, OP_ABORTED, OP_FAIL} = 5'h00;
    ev = 9'h000;
    wdata = 8'h00;
    settle(20);
    SRST = 1'b0;
    settle(6);
    t_reset();
    t_summary_pin();
    t_latch();
    t_lock();
    t_upper();
    t_fail();
    t_serial();
    report_and_stop();
  end
endmodule
